/* File: drcm_top.sv */
// Configuration manager of a radio locomotive decoder
// Notes on behaviour
// - Red indicator steady while matching channel heard
// - Green indicator on while powered and switched
// - Address accepts 1 to 9999, never zero
// - Channel variable 0..16 selects receive channel
// - Factory state: address 3, channel 0
// - One silent minute at power-up: five chirps, channel 0
// - Fallback leaves every stored setting untouched
// - Broadcast mode applies writes at any address
// - Chirp once for each command accepted while the sounder is idle
// - Maker id write schedules reset at next power-up
// - Smoke off two minutes after last trigger
// - Addressed mode applies only own address
`timescale 1ns/1ps
module drcm_top #(
  parameter int SEC_LEN = drcm_pkg::SEC_CYCLES,
  parameter int FB_SECS = drcm_pkg::FALLBACK_S,
  parameter int SM_SECS = drcm_pkg::SMOKE_S,
  parameter int CHIRP_LEN = drcm_pkg::CHIRP_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Power switch and radio pins
  input  wire logic        power_switch_in,
  input  wire logic        carrier_in,
  // Decoded command from the radio receiver, same clock
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_broadcast_in,
  input  wire logic [15:0] cmd_addr_in,
  input  wire logic [7:0]  cmd_var_in,
  input  wire logic [15:0] cmd_value_in,
  input  wire logic        smoke_trigger_in,
  // Nonvolatile store, restored at power-up
  input  wire logic        nv_valid_in,
  input  wire logic [15:0] nv_addr_in,
  input  wire logic [4:0]  nv_chan_in,
  input  wire logic        nv_reset_pend_in,
  output logic             nv_write_out,
  output logic [15:0]      nv_addr_out,
  output logic [4:0]       nv_chan_out,
  output logic             nv_reset_pend_out,
  output logic             factory_defaults_out,
  // Radio, indicators, sounder, smoke
  output logic [4:0]       rx_channel_out,
  output logic             signal_match_indicator_out,
  output logic             power_indicator_out,
  output logic             chirp_out,
  output logic             smoke_out,
  output logic             fallback_out
);
  import drcm_pkg::*;

  typedef enum logic [1:0] {
    S_BOOT = 2'b00,
    S_WAIT = 2'b01,
    S_CHRP = 2'b11,
    S_RUN  = 2'b10
  } drcm_state_t;

  typedef struct packed {
    drcm_state_t fsm;
    logic [1:0]  car_sync;
    logic [1:0]  pwr_sync;
    logic [31:0] sec_cnt;
    logic [7:0]  fb_secs;
    logic [7:0]  sm_secs;
    logic        heard;
    logic        fallback;
    logic        smoke;
    logic [15:0] addr;
    logic [4:0]  chan;
    logic        reset_pend;
    logic        nv_write;
    logic        fact;
    logic        match;
    logic        power;
  } drcm_st_t;

  drcm_st_t    st;
  drcm_st_t    next_st;
  logic        chirp_start;
  logic [2:0]  chirp_count;
  logic        chirp_busy;
  logic        sec_tick;
  logic        for_me;
  logic        in_range;
  logic        accept;

  // One-second enable from the clock divider
  assign sec_tick = (st.sec_cnt == 32'(SEC_LEN - 1));

  // Command qualification
  always_comb begin
    for_me = cmd_broadcast_in || (cmd_addr_in == st.addr);
    in_range = 1'b0;
    case (cmd_var_in)
      ADDR_VAR_NUM:  in_range = (cmd_value_in >= ADDR_MIN) && (cmd_value_in <= ADDR_MAX);
      CHAN_VAR_NUM:  in_range = (cmd_value_in <= CHAN_MAX);
      MAKER_VAR_NUM: in_range = (cmd_value_in == MAKER_ID_VALUE);
      default:       in_range = 1'b0;
    endcase
  end

  assign accept = (st.fsm == S_RUN) && cmd_valid_in && st.car_sync[1] && for_me && in_range;

  // Next-state logic
  always_comb begin
    next_st          = st;
    next_st.car_sync = {st.car_sync[0], carrier_in};
    next_st.pwr_sync = {st.pwr_sync[0], power_switch_in};
    next_st.sec_cnt  = sec_tick ? 32'h0000_0000 : st.sec_cnt + 32'h0000_0001;
    next_st.nv_write = 1'b0;
    next_st.fact     = 1'b0;
    chirp_start      = 1'b0;
    chirp_count      = 3'h1;
    next_st.power    = st.pwr_sync[1];
    next_st.match    = st.car_sync[1];
    if (st.car_sync[1]) begin
      next_st.heard = 1'b1;
    end
    case (st.fsm)
      S_BOOT: begin
        if (nv_valid_in) begin
          // Restore nonvolatile settings or apply pending factory values
          if (nv_reset_pend_in) begin
            next_st.addr       = ADDR_FACTORY;
            next_st.chan       = CHAN_FACTORY;
            next_st.reset_pend = 1'b0;
            next_st.nv_write   = 1'b1;
            next_st.fact       = 1'b1;
          end else begin
            next_st.addr       = ((nv_addr_in < ADDR_MIN) || (nv_addr_in > ADDR_MAX)) ?
                                 ADDR_FACTORY : nv_addr_in;
            next_st.chan       = (nv_chan_in > 5'(CHAN_MAX)) ? CHAN_FACTORY : nv_chan_in;
            next_st.reset_pend = 1'b0;
          end
          next_st.fsm     = S_WAIT;
          next_st.fb_secs = 8'h00;
          next_st.heard   = 1'b0;
        end
      end
      S_WAIT: begin
        if (st.heard || st.car_sync[1]) begin
          next_st.fsm = S_RUN;
        end else if (sec_tick) begin
          if (st.fb_secs == 8'(FB_SECS - 1)) begin
            chirp_start = 1'b1;
            chirp_count = FALLBACK_CHIRPS;
            next_st.fsm = S_CHRP;
          end else begin
            next_st.fb_secs = st.fb_secs + 8'h01;
          end
        end
      end
      S_CHRP: begin
        if (!chirp_busy) begin
          next_st.fallback = 1'b1;
          next_st.fsm      = S_RUN;
        end
      end
      S_RUN: begin
        if (accept) begin
          chirp_start      = 1'b1;
          next_st.nv_write = 1'b1;
          case (cmd_var_in)
            ADDR_VAR_NUM: next_st.addr = cmd_value_in;
            CHAN_VAR_NUM: begin
              next_st.chan     = cmd_value_in[4:0];
              next_st.fallback = 1'b0;
            end
            default: next_st.reset_pend = 1'b1;
          endcase
        end
      end
      default: next_st.fsm = S_BOOT;
    endcase
    // Smoke timer, retrigger restarts it
    if (smoke_trigger_in) begin
      next_st.smoke   = 1'b1;
      next_st.sm_secs = 8'h00;
    end else if (st.smoke && sec_tick) begin
      if (st.sm_secs == 8'(SM_SECS - 1)) begin
        next_st.smoke = 1'b0;
      end else begin
        next_st.sm_secs = st.sm_secs + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st      <= '0;
      st.addr <= ADDR_FACTORY;
      st.fsm  <= S_BOOT;
    end else begin
      st <= next_st;
    end
  end

  // Chirp sounder
  drcm_chirp #(
    .CHIRP_LEN  (CHIRP_LEN)
  ) u_chirp (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (chirp_start),
    .count_in   (chirp_count),
    .busy_out   (chirp_busy),
    .tone_out   (chirp_out)
  );

  // Outputs
  assign rx_channel_out             = st.fallback ? CHAN_FALLBACK : st.chan;
  assign signal_match_indicator_out = st.match;
  assign power_indicator_out        = st.power;
  assign smoke_out                  = st.smoke;
  assign fallback_out               = st.fallback;
  assign nv_write_out               = st.nv_write;
  assign nv_addr_out                = st.addr;
  assign nv_chan_out                = st.chan;
  assign nv_reset_pend_out          = st.reset_pend;
  assign factory_defaults_out       = st.fact;

  // Assertions
  property p_match;
    @(posedge clk_in) disable iff (sys_rst_in)
      !sys_rst_in ##3 1'b1 |-> signal_match_indicator_out == $past(carrier_in, 3);
  endproperty
  a_match: assert property (p_match) else $error("indicator not following carrier");

  property p_addr_nonzero;
    @(posedge clk_in) disable iff (sys_rst_in)
      st.fsm != S_BOOT |-> st.addr != 16'h0000 && st.addr <= ADDR_MAX;
  endproperty
  a_addr_nonzero: assert property (p_addr_nonzero) else $error("address zero adopted");

  property p_reject;
    @(posedge clk_in) disable iff (sys_rst_in)
      cmd_valid_in && !in_range |=> $stable(st.addr) && $stable(st.chan);
  endproperty
  a_reject: assert property (p_reject) else $error("out-of-range write applied");

  property p_ack;
    @(posedge clk_in) disable iff (sys_rst_in) accept |=> chirp_busy;
  endproperty
  a_ack: assert property (p_ack) else $error("no chirp on accepted command");

  property p_other_addr;
    @(posedge clk_in) disable iff (sys_rst_in)
      cmd_valid_in && !cmd_broadcast_in && cmd_addr_in != st.addr |-> !accept;
  endproperty
  a_other_addr: assert property (p_other_addr) else $error("foreign address accepted");

  property p_chan_range;
    @(posedge clk_in) disable iff (sys_rst_in) rx_channel_out <= 5'(CHAN_MAX);
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel out of range");

  property p_fb_keep;
    @(posedge clk_in) disable iff (sys_rst_in)
      $rose(st.fallback) |-> $stable(st.chan) && $stable(st.addr) && $stable(st.reset_pend);
  endproperty
  a_fb_keep: assert property (p_fb_keep) else $error("fallback changed channel");

  property p_smoke_trig;
    @(posedge clk_in) disable iff (sys_rst_in)
      smoke_trigger_in |=> smoke_out && st.sm_secs == 8'h00;
  endproperty
  a_smoke_trig: assert property (p_smoke_trig) else $error("smoke not retriggered");

  property p_smoke_off;
    @(posedge clk_in) disable iff (sys_rst_in)
      $fell(st.smoke) |-> $past(st.sm_secs) == 8'(SM_SECS - 1);
  endproperty
  a_smoke_off: assert property (p_smoke_off) else $error("smoke stopped before timeout");
endmodule // drcm_top

/* File: drcm_pkg.sv */
// Package of constants for the decoder radio configuration manager
package drcm_pkg;
  // Variable numbers
  localparam logic [7:0]  ADDR_VAR_NUM     = 8'h01;
  localparam logic [7:0]  MAKER_VAR_NUM    = 8'h08;
  localparam logic [7:0]  CHAN_VAR_NUM     = 8'hC8;
  // Value limits and factory values
  localparam logic [15:0] ADDR_MIN         = 16'h0001;
  localparam logic [15:0] ADDR_MAX         = 16'h270F;
  localparam logic [15:0] CHAN_MAX         = 16'h0010;
  localparam logic [15:0] ADDR_FACTORY     = 16'h0003;
  localparam logic [4:0]  CHAN_FACTORY     = 5'h00;
  localparam logic [4:0]  CHAN_FALLBACK    = 5'h00;
  // Maker identification value, arbitrary
  localparam logic [15:0] MAKER_ID_VALUE   = 16'h005A;
  // Chirp behaviour
  localparam logic [2:0]  FALLBACK_CHIRPS  = 3'h5;
  localparam int          CLK_HZ           = 25_000_000;
  localparam int          CHIRP_MS         = 100;
  localparam int          CHIRP_CYCLES     = CLK_HZ / 1000 * CHIRP_MS;
  // Long timeouts in seconds
  localparam int          FALLBACK_S       = 60;
  localparam int          SMOKE_S          = 120;
  // Second tick divider
  localparam int          SEC_CYCLES       = CLK_HZ;
endpackage : drcm_pkg

/* File: drcm_chirp.sv */
// Chirp sequencer: plays a burst of tone pulses
`timescale 1ns/1ps
module drcm_chirp #(
  parameter int CHIRP_LEN = drcm_pkg::CHIRP_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // Request
  input  wire logic       start_in,
  input  wire logic [2:0] count_in,
  // Status and tone
  output logic            busy_out,
  output logic            tone_out
);
  import drcm_pkg::*;

  typedef struct packed {
    logic [2:0]  left;
    logic        on;
    logic [31:0] cnt;
  } drcm_chirp_st_t;

  drcm_chirp_st_t st;
  drcm_chirp_st_t next_st;

  // Alternating tone and gap of one chirp length each
  always_comb begin
    next_st = st;
    if (st.left != 3'h0) begin
      if (st.cnt == 32'(CHIRP_LEN - 1)) begin
        next_st.cnt = 32'h0000_0000;
        next_st.on  = ~st.on;
        if (!st.on) begin
          next_st.left = st.left - 3'h1;
        end
      end else begin
        next_st.cnt = st.cnt + 32'h0000_0001;
      end
    end else if (start_in) begin
      next_st.left = count_in;
      next_st.on   = 1'b1;
      next_st.cnt  = 32'h0000_0000;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_out = (st.left != 3'h0);
  assign tone_out = st.on && (st.left != 3'h0);
endmodule // drcm_chirp

/* File: drcm_throttle.sv */
// Behavioural handheld throttle that tunes, keys its carrier and sends write commands
`timescale 1ns/1ps
module drcm_throttle (
  // Clock and decoder channel
  input  wire logic        clk_in,
  input  wire logic [4:0]  rx_channel_in,
  // Radio carrier and decoded command
  output logic             carrier_out,
  output logic             cmd_valid_out,
  output logic             cmd_broadcast_out,
  output logic [15:0]      cmd_addr_out,
  output logic [7:0]       cmd_var_out,
  output logic [15:0]      cmd_value_out
);
  logic       on;
  logic [4:0] chan;
  // Heard only while keyed and tuned to the decoder; bench powers one decoder alone
  assign carrier_out = on && (chan == rx_channel_in);
  // Idle at start
  initial begin
    on = 1'b0;
    chan = 5'h00;
    cmd_valid_out = 1'b0;
    cmd_broadcast_out = 1'b0;
    cmd_addr_out = 16'h0000;
    cmd_var_out = 8'h00;
    cmd_value_out = 16'h0000;
  end
  // Switch on or off and pick a channel
  task tune(input logic o, input logic [4:0] c);
    @(negedge clk_in);
    on = o;
    chan = c;
  endtask
  // One-cycle command, fields scrambled once released
  task send(input logic bc, input logic [15:0] a, input logic [7:0] v, input logic [15:0] d);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_broadcast_out = bc;
    cmd_addr_out = a;
    cmd_var_out = v;
    cmd_value_out = d;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_broadcast_out = ~bc;
    cmd_addr_out = ~a;
    cmd_var_out = ~v;
    cmd_value_out = ~d;
  endtask
endmodule // drcm_throttle

/* File: drcm_top_test.sv */
// Self-checking bench for the decoder radio configuration manager
`timescale 1ns/1ps
module drcm_top_test;
  import drcm_pkg::*;
  logic        clk_in, sys_rst_in, power_sw, carrier, cmd_valid, cmd_bc, smoke_trig;
  logic        nv_wr, nv_pend_out, st_pend, fact, match, power_led, chirp, smoke, fb;
  logic [15:0] cmd_addr, cmd_value, nv_addr_out, st_addr;
  logic [7:0]  cmd_var;
  logic [4:0]  nv_chan_out, st_chan, rx_chan;
  logic        nv_valid, prev_chirp;
  int          n_errors, check_count, i, n_chirps;

  // Design and throttle
  drcm_top #(.SEC_LEN(10), .FB_SECS(3), .SM_SECS(3), .CHIRP_LEN(4)) u_drcm_top (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .power_switch_in(power_sw),
    .carrier_in(carrier), .cmd_valid_in(cmd_valid), .cmd_broadcast_in(cmd_bc),
    .cmd_addr_in(cmd_addr), .cmd_var_in(cmd_var), .cmd_value_in(cmd_value),
    .smoke_trigger_in(smoke_trig), .nv_valid_in(nv_valid), .nv_addr_in(st_addr),
    .nv_chan_in(st_chan), .nv_reset_pend_in(st_pend), .nv_write_out(nv_wr),
    .nv_addr_out(nv_addr_out), .nv_chan_out(nv_chan_out), .nv_reset_pend_out(nv_pend_out),
    .factory_defaults_out(fact), .rx_channel_out(rx_chan),
    .signal_match_indicator_out(match), .power_indicator_out(power_led),
    .chirp_out(chirp), .smoke_out(smoke), .fallback_out(fb));
  drcm_throttle u_drcm_throttle (
    .clk_in(clk_in), .rx_channel_in(rx_chan), .carrier_out(carrier),
    .cmd_valid_out(cmd_valid), .cmd_broadcast_out(cmd_bc), .cmd_addr_out(cmd_addr),
    .cmd_var_out(cmd_var), .cmd_value_out(cmd_value));

  // Nonvolatile store kept across power cycles
  always @(posedge clk_in) begin
    if (nv_wr === 1'b1) begin
      st_addr <= nv_addr_out;
      st_chan <= nv_chan_out;
      st_pend <= nv_pend_out;
    end
  end

  // Clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task end_sim;
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task check_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task boot;
    sys_rst_in = 1'b1;
    cyc(12);
    sys_rst_in = 1'b0;
  endtask
  task send(input logic bc, input logic [15:0] a, input logic [7:0] v, input logic [15:0] d);
    u_drcm_throttle.send(bc, a, v, d);
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    sys_rst_in = 1'b1;
    power_sw = 1'b1;
    smoke_trig = 1'b0;
    nv_valid = 1'b1;
    st_addr = 16'h0003;
    st_chan = 5'h00;
    st_pend = 1'b0;
    n_errors = 0;
    check_count = 0;
    boot();
    cyc(10);
    check_bit(power_led, 1'b1);
    check_val({11'h000, rx_chan}, 16'h0000);
    u_drcm_throttle.tune(1'b1, 5'h00);
    cyc(5);
    check_bit(match, 1'b1);
    // Refused writes leave no trace
    send(1'b1, 16'h0000, ADDR_VAR_NUM, 16'h0000);
    check_bit(nv_wr, 1'b0);
    check_bit(chirp, 1'b0);
    send(1'b1, 16'h0000, ADDR_VAR_NUM, 16'h2710);
    check_bit(nv_wr, 1'b0);
    send(1'b1, 16'h0000, CHAN_VAR_NUM, 16'h0011);
    check_bit(nv_wr, 1'b0);
    send(1'b1, 16'h0000, 8'h05, 16'h0001);
    check_bit(nv_wr, 1'b0);
    // Broadcast write at a foreign address
    send(1'b1, 16'h1234, ADDR_VAR_NUM, 16'h270F);
    check_bit(nv_wr, 1'b1);
    check_val(nv_addr_out, 16'h270F);
    check_bit(chirp, 1'b1);
    // Addressed writes, then broadcast writes
    send(1'b0, 16'h1234, CHAN_VAR_NUM, 16'h0007);
    check_bit(nv_wr, 1'b0);
    send(1'b0, 16'h270F, CHAN_VAR_NUM, 16'h0010);
    check_bit(nv_wr, 1'b1);
    check_val({11'h000, rx_chan}, 16'h0010);
    cyc(5);
    check_bit(match, 1'b0);
    u_drcm_throttle.tune(1'b1, 5'h10);
    cyc(5);
    check_bit(match, 1'b1);
    send(1'b1, 16'h0000, ADDR_VAR_NUM, 16'h0001);
    check_val(nv_addr_out, 16'h0001);
    send(1'b1, 16'h0000, CHAN_VAR_NUM, 16'h0005);
    check_val({11'h000, nv_chan_out}, 16'h0005);
    // Smoke timeout and retrigger
    smoke_trig = 1'b1;
    cyc(1);
    smoke_trig = 1'b0;
    cyc(20);
    check_bit(smoke, 1'b1);
    smoke_trig = 1'b1;
    cyc(1);
    smoke_trig = 1'b0;
    cyc(15);
    check_bit(smoke, 1'b1);
    cyc(40);
    check_bit(smoke, 1'b0);
    // Silent power-up keeps stored settings and chirps after the wait
    u_drcm_throttle.tune(1'b0, 5'h05);
    nv_valid = 1'b0;
    boot();
    cyc(10);
    check_val(nv_addr_out, 16'h0003);
    nv_valid = 1'b1;
    cyc(1);
    check_val({11'h000, rx_chan}, 16'h0005);
    check_val(nv_addr_out, 16'h0001);
    check_bit(chirp, 1'b0);
    for (i = 0; i < 100 && chirp !== 1'b1; i++) cyc(1);
    check_bit(i >= 15, 1'b1);
    check_bit(chirp, 1'b1);
    check_val({11'h000, rx_chan}, 16'h0005);
    check_bit(fb, 1'b0);
    // Count the chirps until the temporary channel takes over
    n_chirps = 1;
    prev_chirp = 1'b1;
    for (i = 0; i < 100 && fb !== 1'b1; i++) begin
      cyc(1);
      if (chirp === 1'b1 && prev_chirp !== 1'b1) n_chirps++;
      prev_chirp = chirp;
    end
    check_val(16'(n_chirps), 16'h0005);
    check_bit(fb, 1'b1);
    check_val({11'h000, rx_chan}, 16'h0000);
    check_val({11'h000, nv_chan_out}, 16'h0005);
    check_val(nv_addr_out, 16'h0001);
    u_drcm_throttle.tune(1'b1, 5'h00);
    cyc(5);
    check_bit(match, 1'b1);
    // Maker id write schedules factory values for the next boot
    u_drcm_throttle.tune(1'b1, 5'h05);
    boot();
    cyc(10);
    send(1'b1, 16'h0000, MAKER_VAR_NUM, MAKER_ID_VALUE + 16'h0001);
    check_bit(nv_wr, 1'b0);
    send(1'b1, 16'h0000, MAKER_VAR_NUM, MAKER_ID_VALUE);
    check_bit(nv_pend_out, 1'b1);
    check_val({11'h000, rx_chan}, 16'h0005);
    boot();
    for (i = 0; i < 50 && fact !== 1'b1; i++) cyc(1);
    check_bit(fact, 1'b1);
    cyc(2);
    check_val(nv_addr_out, 16'h0003);
    check_val({11'h000, rx_chan}, 16'h0000);
    check_bit(nv_pend_out, 1'b0);
    // Switch off
    power_sw = 1'b0;
    cyc(5);
    check_bit(power_led, 1'b0);
    end_sim();
  end
endmodule // drcm_top_test
